// *** logic/bfpl_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Device keeps outputs off until both supply monitors are above threshold.
// R2 - Hold both pair resets low at power-up; device then precharges bootstraps.
// R3 - Device runs while supplies are good; hold pair resets low at power-down.
// R4 - Fault and warning are active-low open-drain lines that read high released.
// R5 - Fault line goes low for any shutdown: thermal, overcurrent or undervoltage.
// R6 - Warning line goes low while junction is above the warning temperature.
// R7 - Fault and warning pair encode shutdown, warning, normal, or both.
// R8 - On a shutdown fault the device floats outputs and pulls fault low.
// R9 - Faults other than overcurrent and thermal recover on their own.
// R10 - Wait at least one second after shutdown before pulsing pair resets.
// R11 - Device inserts recharge gaps while the bootstrap voltage is too low.
// R12 - Too short off time per cycle may also start bootstrap recharging.
// R13 - Command the low side on for at least the minimum every cycle.
// R14 - Each switch has its own overcurrent detector with a shared threshold.
// R15 - Mode pins select per-cycle limiting or latched overcurrent shutdown.
// R16 - Per-cycle mode limits current within the cycle, without shutdown.
// R17 - In per-cycle mode an uncontained short latches that half-bridge off.
// R18 - Limiting and shutdown are handled separately for each half-bridge.
// R19 - Per-cycle limit overrides the switches until the next PWM cycle; the stage model holds it only while oc_hit is high.
// R20 - Latched mode shuts down; pulse the pair reset to resume afterwards.
// R21 - Thermal shutdown latches; both pair resets must go low to clear it.
// R22 - Each pair reset clears only its own half-bridges; fault ORs all.
module bfpl_host
  import bfpl_pkg::*;
#(
  parameter longint HOLD_CYCLES = SHUT_WAIT_CYC
)(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [31:0]        reg_rdata,
  // Status lines from the power stage
  input  wire logic               fault_n,
  input  wire logic               overheat_warning_n,
  // Control lines to the power stage
  output var  logic               pair_one_reset_n,
  output var  logic               pair_two_reset_n,
  output var  logic               per_cycle_limit_mode,
  output var  logic               latched_trip_mode,
  output var  logic [NUM_CH-1:0]  pwm_out
);

  // -------------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------------
  // Returns {hit, index} for the four duty words
  function automatic logic [2:0] duty_sel(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_DUTY0;
    if (a >= ADDR_DUTY0 && off < 8'h10 && off[1:0] == 2'h0) begin
      duty_sel = {1'b1, off[3:2]};
    end else begin
      duty_sel = 3'h0;
    end
  endfunction

  // Meaning of the fault and warning pair
  function automatic bfpl_status_e decode_status(input logic f_n, input logic w_n);
    if (!f_n && !w_n) begin
      decode_status = BFPL_ST_WARN_SHUT;
    end else if (!f_n) begin
      decode_status = BFPL_ST_SHUT;
    end else if (!w_n) begin
      decode_status = BFPL_ST_WARN;
    end else begin
      decode_status = BFPL_ST_NORMAL;
    end
  endfunction

  bfpl_host_s q;
  bfpl_host_s d;

  logic [HOLD_W-1:0] hold_limit;
  assign hold_limit = HOLD_W'(HOLD_CYCLES);

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb begin
    logic         fault_fell;
    logic         hold_done;
    logic         wrap;
    logic [2:0]   dsel;
    logic [PWM_W:0] span;
    logic [PWM_W-1:0] lim;
    fault_fell = 1'b0;
    hold_done  = 1'b0;
    wrap       = 1'b0;
    dsel       = 3'h0;
    span       = '0;
    lim        = '0;
    d          = q;

    // Pins are asynchronous; a change counts once stages two and three agree
    d.flt_sync  = {q.flt_sync[1:0], fault_n};
    d.warn_sync = {q.warn_sync[1:0], overheat_warning_n};
    if (q.flt_sync[1] == q.flt_sync[2]) begin
      d.flt_stable = q.flt_sync[2];             // [R4]
    end
    if (q.warn_sync[1] == q.warn_sync[2]) begin
      d.warn_stable = q.warn_sync[2];           // [R4]
    end
    fault_fell = q.flt_stable && !d.flt_stable && q.run;

    // Time since the last shutdown, saturating once the wait is over
    hold_done = (q.hold_cnt >= hold_limit);
    if (fault_fell) begin
      d.hold_cnt = '0;                          // [R10]
    end else if (!hold_done) begin
      d.hold_cnt = q.hold_cnt + 1'b1;
    end

    // Shared PWM counter; new settings take effect at a cycle boundary, or at once while PWM is off
    wrap = (q.cnt >= q.act_period);
    if (!q.pwm_en) begin
      d.cnt = '0;
    end else if (wrap) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
    if (!q.pwm_en || wrap) begin
      d.act_period = q.period;
      // Clamp the high time so the low side always gets its minimum
      span = {1'b0, q.period} + 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
        if (span > (PWM_W+1)'(MIN_LOW_CYC)) begin
          lim = PWM_W'(span - (PWM_W+1)'(MIN_LOW_CYC));  // [R13]
        end else begin
          lim = '0;
        end
        d.act_lim[i] = (q.duty[i] < lim) ? q.duty[i] : lim;
      end
    end

    // Register writes
    dsel = duty_sel(reg_addr);
    if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        d.run        = reg_wdata[CTRL_RUN_BIT];
        d.latch_mode = reg_wdata[CTRL_LATCH_BIT];
        d.pwm_en     = reg_wdata[CTRL_PWM_BIT];
      end else if (reg_addr == ADDR_PERIOD) begin
        d.period = reg_wdata[PWM_W-1:0];
      end else if (dsel[2]) begin
        d.duty[dsel[1:0]] = reg_wdata[PWM_W-1:0];
      end else if (reg_addr == ADDR_STATUS && reg_wdata[STAT_SHUT_BIT]) begin
        d.shut_seen = 1'b0;
      end
    end

    // Sticky shutdown flag; a new shutdown wins over a clear in the same cycle
    if (fault_fell) begin
      d.shut_seen = 1'b1;                       // [R5]
      if (!d.warn_stable) begin
        d.thermal = 1'b1;                       // [R21]
      end
    end

    // Recovery sequence
    case (q.rc)
      BFPL_RC_IDLE: begin
        if (reg_wr && reg_addr == ADDR_CMD && q.run
            && (reg_wdata[CMD_PAIR1_BIT] || reg_wdata[CMD_PAIR2_BIT])) begin
          d.rc_mask = {reg_wdata[CMD_PAIR2_BIT], reg_wdata[CMD_PAIR1_BIT]};  // [R20]
          if (q.thermal) begin
            d.rc_mask = 2'h3;                   // [R21]
          end
          d.pulse_cnt = '0;
          d.rc        = hold_done ? BFPL_RC_PULSE : BFPL_RC_WAIT;           // [R10]
        end
      end
      BFPL_RC_WAIT: begin
        if (!q.run) begin
          d.rc = BFPL_RC_IDLE;
        end else if (hold_done) begin
          d.rc = BFPL_RC_PULSE;                 // [R10]
        end
      end
      BFPL_RC_PULSE: begin
        d.pulse_cnt = q.pulse_cnt + 1'b1;
        if (q.pulse_cnt == PULSE_W'(PULSE_CYC - 1)) begin
          d.rc = BFPL_RC_IDLE;
          // A thermal trip in the closing cycle wins over the clear
          if (q.rc_mask == 2'h3 && !(fault_fell && !d.warn_stable)) begin
            d.thermal = 1'b0;                   // [R21]
          end
        end
      end
      default: begin
        d.rc = BFPL_RC_IDLE;
      end
    endcase

    // Pair resets stay low until run is set and drop while stopped or while their own pair is pulsed
    d.rst_one_n = q.run && !(q.rc == BFPL_RC_PULSE && q.rc_mask[0]);  // [R2] [R3] [R20]
    d.rst_two_n = q.run && !(q.rc == BFPL_RC_PULSE && q.rc_mask[1]);  // [R2] [R3] [R20]

    // Mode pins only move while the stage is held in reset, never mid-run
    if (!q.run) begin
      d.mode_cbc   = !q.latch_mode;             // [R15]
      d.mode_latch = q.latch_mode;              // [R15]
    end

    // Read data stands in the cycle after the strobe only
    d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        d.rdata[CTRL_RUN_BIT]   = q.run;
        d.rdata[CTRL_LATCH_BIT] = q.latch_mode;
        d.rdata[CTRL_PWM_BIT]   = q.pwm_en;
      end else if (reg_addr == ADDR_PERIOD) begin
        d.rdata[PWM_W-1:0] = q.period;
      end else if (dsel[2]) begin
        d.rdata[PWM_W-1:0] = q.duty[dsel[1:0]];
      end else if (reg_addr == ADDR_STATUS) begin
        d.rdata[STAT_FAULT_BIT] = q.flt_stable;
        d.rdata[STAT_WARN_BIT]  = q.warn_stable;
        d.rdata[STAT_CODE_LSB +: 2] = decode_status(q.flt_stable, q.warn_stable);  // [R7]
        d.rdata[STAT_SHUT_BIT]  = q.shut_seen;
        d.rdata[STAT_THERM_BIT] = q.thermal;
        d.rdata[STAT_BUSY_BIT]  = (q.rc != BFPL_RC_IDLE);
        d.rdata[STAT_READY_BIT] = hold_done;
      end
    end
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q             <= '0;
      q.flt_sync    <= SYNC_RST;
      q.warn_sync   <= SYNC_RST;
      q.flt_stable  <= 1'b1;
      q.warn_stable <= 1'b1;
      q.period      <= PERIOD_RST;
      q.duty        <= {NUM_CH{DUTY_RST}};
      q.hold_cnt    <= {HOLD_W{1'b1}};   // No shutdown yet, so no wait pending
      q.rc          <= BFPL_RC_IDLE;
      q.mode_cbc    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs and PWM channels
  // -------------------------------------------------------------------------
  assign reg_rdata            = q.rdata;
  assign pair_one_reset_n     = q.rst_one_n;
  assign pair_two_reset_n     = q.rst_two_n;
  assign per_cycle_limit_mode = q.mode_cbc;
  assign latched_trip_mode    = q.mode_latch;

  // A channel only switches while its pair is out of reset
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      bfpl_pwm_chan u_chan (
        .sys_clk (sys_clk),
        .reset   (reset),
        .enable  (q.pwm_en && (g < 2 ? q.rst_one_n : q.rst_two_n)),
        .count   (q.cnt),
        .limit   (q.act_lim[g]),
        .pwm_q   (pwm_out[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  chk_reset_held: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
    !q.run |=> (!pair_one_reset_n && !pair_two_reset_n))
    else $error("pair reset released while stopped");

  chk_release_needs_run: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
    (pair_one_reset_n || pair_two_reset_n) |-> $past(q.run))
    else $error("pair reset high without run");

  chk_wait_elapsed: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
    $rose(q.rc == BFPL_RC_PULSE) |-> ($past(q.hold_cnt) >= hold_limit))
    else $error("recovery pulse before shutdown wait elapsed");

  chk_pulse_length: assert property (@(posedge sys_clk) disable iff (reset) // [R20]
    $fell(q.rc == BFPL_RC_PULSE) |-> ($past(q.pulse_cnt) == PULSE_W'(PULSE_CYC - 1)))
    else $error("recovery pulse has wrong length");

  chk_pair_select: assert property (@(posedge sys_clk) disable iff (reset) // [R20]
    (q.rc == BFPL_RC_PULSE && !q.rc_mask[1] && q.run) |=> pair_two_reset_n)
    else $error("unselected pair was reset");

  chk_thermal_both: assert property (@(posedge sys_clk) disable iff (reset) // [R21]
    (q.rc == BFPL_RC_PULSE && q.thermal) |-> (q.rc_mask == 2'h3))
    else $error("thermal recovery did not reset both pairs");

  chk_mode_onehot: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
    per_cycle_limit_mode != latched_trip_mode)
    else $error("mode pins not one-hot");

  chk_mode_stable: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
    !$stable(latched_trip_mode) |-> !$past(q.run))
    else $error("mode pins changed while running");

endmodule // bfpl_host
`default_nettype wire

// *** logic/bfpl_pkg.sv ***
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants and types of the bridge protection controller
// ---------------------------------------------------------------------------
package bfpl_pkg;

  // -------------------------------------------------------------------------
  // Clock and timing
  // -------------------------------------------------------------------------
  localparam longint CLK_PERIOD_NS   = 8;
  localparam longint SHUT_WAIT_NS    = 1000000000;   // Least wait after shutdown, 1 s
  localparam longint MIN_LOW_NS      = 50;           // Least low-side on time per cycle
  localparam longint RECOVER_PULSE_NS = 1000;        // Width of a recovery reset pulse
  // Least times round up to whole cycles
  localparam longint SHUT_WAIT_CYC   = (SHUT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int     MIN_LOW_CYC     = int'((MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int     PULSE_CYC       = int'((RECOVER_PULSE_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS);
  localparam int     HOLD_W          = 28;
  localparam int     PULSE_W         = 8;
  localparam int     PWM_W           = 16;
  localparam int     NUM_CH          = 4;

  // -------------------------------------------------------------------------
  // Register map (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_DUTY0  = 8'h10;   // Four duty words follow, one per half-bridge

  // Control register fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam int CTRL_PWM_BIT   = 2;
  // Command register fields
  localparam int CMD_PAIR1_BIT  = 0;
  localparam int CMD_PAIR2_BIT  = 1;
  // Status register fields
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_WARN_BIT  = 1;
  localparam int STAT_CODE_LSB  = 2;
  localparam int STAT_SHUT_BIT  = 4;
  localparam int STAT_THERM_BIT = 5;
  localparam int STAT_BUSY_BIT  = 6;
  localparam int STAT_READY_BIT = 7;

  // Reset values
  localparam logic [PWM_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [PWM_W-1:0] DUTY_RST   = 16'h0000;
  localparam logic [2:0]       SYNC_RST   = 3'h7;     // Released open-drain lines read high

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BFPL_ST_NORMAL, BFPL_ST_WARN, BFPL_ST_SHUT, BFPL_ST_WARN_SHUT
  } bfpl_status_e;

  typedef enum logic [1:0] {
    BFPL_RC_IDLE, BFPL_RC_WAIT, BFPL_RC_PULSE
  } bfpl_rc_e;

  typedef struct packed {
    logic [2:0]                   flt_sync;
    logic [2:0]                   warn_sync;
    logic                         flt_stable;
    logic                         warn_stable;
    logic                         run;
    logic                         latch_mode;
    logic                         pwm_en;
    logic [PWM_W-1:0]             period;
    logic [NUM_CH-1:0][PWM_W-1:0] duty;
    logic [PWM_W-1:0]             cnt;
    logic [PWM_W-1:0]             act_period;
    logic [NUM_CH-1:0][PWM_W-1:0] act_lim;
    logic                         shut_seen;
    logic                         thermal;
    bfpl_rc_e                     rc;
    logic [1:0]                   rc_mask;
    logic [HOLD_W-1:0]            hold_cnt;
    logic [PULSE_W-1:0]           pulse_cnt;
    logic                         rst_one_n;
    logic                         rst_two_n;
    logic                         mode_cbc;
    logic                         mode_latch;
    logic [31:0]                  rdata;
  } bfpl_host_s;

  typedef struct packed {
    logic pwm;
  } bfpl_chan_s;

endpackage
`default_nettype wire

// *** logic/bfpl_pwm_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// One half-bridge PWM channel
// ---------------------------------------------------------------------------
module bfpl_pwm_chan
  import bfpl_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Timing from the shared counter
  input  wire logic             enable,
  input  wire logic [PWM_W-1:0] count,
  input  wire logic [PWM_W-1:0] limit,
  // Gate command, high means high side on
  output var  logic             pwm_q
);

  bfpl_chan_s q;
  bfpl_chan_s d;

  // High side on while the count is below the clamped limit
  always_comb begin
    d     = q;
    d.pwm = enable && (count < limit);   // [R13]
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pwm_q = q.pwm;

  // Every low phase lasts at least the minimum low-side time
  chk_low_min: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
    $fell(q.pwm) |-> (!q.pwm) [*7])
    else $error("low-side on time shorter than minimum");

endmodule // bfpl_pwm_chan
`default_nettype wire

// *** tb/bfpl_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------
// Behavioural power stage: protection latches and open-drain status lines
// ----------
module bfpl_dev_model (
  // Pins from the controller
  input  wire logic       pair_one_reset_n,
  input  wire logic       pair_two_reset_n,
  input  wire logic       per_cycle_limit_mode,
  input  wire logic       latched_trip_mode,
  input  wire logic [3:0] pwm_in,
  // Conditions forced by the bench
  input  wire logic       gate_ok,
  input  wire logic       logic_ok,
  input  wire logic       hot,
  input  wire logic       overheat,
  input  wire logic [3:0] oc_hit,
  input  wire logic [3:0] short_hit,
  // Open-drain status lines
  output wire logic       fault_n,
  output wire logic       overheat_warning_n,
  // Stage state, for inspection
  output var  logic [3:0] bridge_hiz,
  output var  logic [3:0] low_side_on
);
  logic [3:0] oc_lat    = 4'h0;
  logic       therm_lat = 1'b0;
  logic       uv;
  logic [3:0] pr;

  assign pr = {pair_two_reset_n, pair_two_reset_n, pair_one_reset_n, pair_one_reset_n};
  // Either supply below threshold floats everything, recovers by itself
  assign uv = !gate_ok || !logic_ok;

  // Per-bridge trip latch; only that bridge's pair reset clears it
  always @* begin
    for (int i = 0; i < 4; i++) begin
      if (!pr[i]) oc_lat[i] = 1'b0;
      else if (oc_hit[i] && (latched_trip_mode || short_hit[i])) oc_lat[i] = 1'b1;
    end
  end

  // Thermal trip holds until both pairs are reset together
  always @* begin
    if (!pair_one_reset_n && !pair_two_reset_n) therm_lat = 1'b0;
    else if (overheat) therm_lat = 1'b1;
  end

  // Pullups make a released line read high, never the last driven value
  assign fault_n            = !(uv || therm_lat || (|oc_lat));
  assign overheat_warning_n = !hot;

  // Stage state; a held pair reset means weak pulldown for precharge
  always @* begin
    for (int i = 0; i < 4; i++) begin
      bridge_hiz[i]  = uv || therm_lat || oc_lat[i] || !pr[i];
      // A per-cycle trip swaps to the low side while it lasts, no shutdown
      low_side_on[i] = !bridge_hiz[i] && (!pwm_in[i] || (per_cycle_limit_mode && oc_hit[i]));
    end
  end
endmodule // bfpl_dev_model
`default_nettype wire

// *** tb/bfpl_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------
// Self-checking bench of the bridge protection controller
// ----------
module bfpl_host_tb;
  import bfpl_pkg::*;
  // Short hold so a recovery fits in a few hundred cycles
  localparam longint HOLD = 200;
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  wire logic   fault_n;
  wire logic   overheat_warning_n;
  logic        pair_one_reset_n;
  logic        pair_two_reset_n;
  logic        per_cycle_limit_mode;
  logic        latched_trip_mode;
  logic [3:0]  pwm_out;
  logic        gate_ok   = 1'b1;
  logic        logic_ok  = 1'b1;
  logic        hot       = 1'b0;
  logic        overheat  = 1'b0;
  logic [3:0]  oc_hit    = 4'h0;
  logic [3:0]  short_hit = 4'h0;
  int          errors    = 0;
  int          compares  = 0;
  longint      cyc       = 0;
  longint      ev_cyc    = 0;

  // ----------
  // Clock, cycle count and instances
  // ----------
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  bfpl_host #(.HOLD_CYCLES(HOLD)) uut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_n(fault_n),
    .overheat_warning_n(overheat_warning_n), .pair_one_reset_n(pair_one_reset_n),
    .pair_two_reset_n(pair_two_reset_n), .per_cycle_limit_mode(per_cycle_limit_mode),
    .latched_trip_mode(latched_trip_mode), .pwm_out(pwm_out));

  bfpl_dev_model u_dev (
    .pair_one_reset_n(pair_one_reset_n), .pair_two_reset_n(pair_two_reset_n),
    .per_cycle_limit_mode(per_cycle_limit_mode), .latched_trip_mode(latched_trip_mode),
    .pwm_in(pwm_out), .gate_ok(gate_ok), .logic_ok(logic_ok), .hot(hot),
    .overheat(overheat), .oc_hit(oc_hit), .short_hit(short_hit), .fault_n(fault_n),
    .overheat_warning_n(overheat_warning_n), .bridge_hiz(), .low_side_on());

  // ----------
  // Shared helpers
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic [31:0] stat(input logic f, w, s, t, r);
    logic [31:0] v;
    v = 32'h0;
    v[STAT_FAULT_BIT]   = f;
    v[STAT_WARN_BIT]    = w;
    v[STAT_CODE_LSB+:2] = {~f, ~w};
    v[STAT_SHUT_BIT]    = s;
    v[STAT_THERM_BIT]   = t;
    v[STAT_READY_BIT]   = r;
    return v;
  endfunction

  function automatic logic [31:0] ctl(input logic run, lat, pwm);
    logic [31:0] v;
    v = 32'h0;
    v[CTRL_RUN_BIT]   = run;
    v[CTRL_LATCH_BIT] = lat;
    v[CTRL_PWM_BIT]   = pwm;
    return v;
  endfunction

  task automatic rs(input logic [31:0] exp);
    logic [31:0] v;
    rd(ADDR_STATUS, v);
    check(v, exp);
  endtask

  task automatic clr_shut;
    wr(ADDR_STATUS, 32'h1 << STAT_SHUT_BIT);
  endtask

  // One-cycle condition pulse into the stage, then let the synchroniser settle
  task automatic fire(input logic [3:0] oc, input logic [3:0] sh, input logic ov);
    @(posedge sys_clk);
    oc_hit    <= oc;
    short_hit <= sh;
    overheat  <= ov;
    ev_cyc    <= cyc;
    @(posedge sys_clk);
    oc_hit    <= 4'h0;
    short_hit <= 4'h0;
    overheat  <= 1'b0;
    tick(8);
  endtask

  // Order a recovery, then time the wait and the width of each pair pulse
  task automatic recover(input logic [1:0] sel, input logic [1:0] pulsed);
    int first = -1;
    int w1    = 0;
    int w2    = 0;
    wr(ADDR_CMD, {30'h0, sel});
    for (int i = 0; i < 800; i++) begin
      tick(1);
      if (!pair_one_reset_n) w1++;
      if (!pair_two_reset_n) w2++;
      if (first < 0 && !(pair_one_reset_n && pair_two_reset_n)) first = int'(cyc - ev_cyc);
    end
    check({31'h0, first >= int'(HOLD)}, 32'h1);
    check(32'(w1), pulsed[0] ? 32'(PULSE_CYC) : 32'h0);
    check(32'(w2), pulsed[1] ? 32'(PULSE_CYC) : 32'h0);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    logic [31:0] v;
    check({pair_one_reset_n, pair_two_reset_n, per_cycle_limit_mode, latched_trip_mode,
           pwm_out}, 32'h20);
    rs(stat(1, 1, 0, 0, 1));
    rd(8'h40, v);
    check(v, 32'h0);
    rd(ADDR_CMD, v);
    check(v, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_modes;
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTRL, ctl(0, m[0], 0));
      tick(2);
      check({per_cycle_limit_mode, latched_trip_mode}, m[0] ? 2'b01 : 2'b10);
      check({pair_one_reset_n, pair_two_reset_n}, 2'b00);
    end
    wr(ADDR_CTRL, ctl(1, 1, 0));
    tick(2);
    check({pair_one_reset_n, pair_two_reset_n, latched_trip_mode}, 3'b111);
    $display("t_modes done");
  endtask

  task automatic t_warn;
    @(posedge sys_clk);
    hot <= 1'b1;
    tick(8);
    rs(stat(1, 0, 0, 0, 1));
    check({pair_one_reset_n, pair_two_reset_n}, 2'b11);
    @(posedge sys_clk);
    hot <= 1'b0;
    tick(8);
    rs(stat(1, 1, 0, 0, 1));
    $display("t_warn done");
  endtask

  // Each supply monitor in turn: shutdown reported, then self recovery
  task automatic t_uv;
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      if (s == 0) gate_ok <= 1'b0;
      else logic_ok <= 1'b0;
      tick(8);
      rs(stat(0, 1, 1, 0, 0));
      @(posedge sys_clk);
      gate_ok  <= 1'b1;
      logic_ok <= 1'b1;
      tick(8);
      rs(stat(1, 1, 1, 0, 0));
      clr_shut;
      rs(stat(1, 1, 0, 0, 0));
      tick(int'(HOLD));
      rs(stat(1, 1, 0, 0, 1));
    end
    $display("t_uv done");
  endtask

  task automatic t_oc(input int ch);
    logic [1:0] pair;
    pair = (ch < 2) ? 2'b01 : 2'b10;
    fire(4'(1 << ch), 4'h0, 1'b0);
    rs(stat(0, 1, 1, 0, 0));
    recover(pair, pair);
    rs(stat(1, 1, 1, 0, 1));
    clr_shut;
    $display("t_oc done");
  endtask

  task automatic t_thermal;
    @(posedge sys_clk);
    hot <= 1'b1;
    fire(4'h0, 4'h0, 1'b1);
    rs(stat(0, 0, 1, 1, 0));
    @(posedge sys_clk);
    hot <= 1'b0;
    tick(8);
    rs(stat(0, 1, 1, 1, 0));
    recover(2'b01, 2'b11);
    rs(stat(1, 1, 1, 0, 1));
    clr_shut;
    $display("t_thermal done");
  endtask

  task automatic t_cbc;
    wr(ADDR_CTRL, ctl(0, 0, 0));
    tick(2);
    wr(ADDR_CTRL, ctl(1, 0, 0));
    tick(2);
    check({per_cycle_limit_mode, latched_trip_mode}, 2'b10);
    fire(4'h2, 4'h0, 1'b0);
    rs(stat(1, 1, 0, 0, 1));
    fire(4'h2, 4'h2, 1'b0);
    rs(stat(0, 1, 1, 0, 0));
    recover(2'b01, 2'b01);
    clr_shut;
    $display("t_cbc done");
  endtask

  // High time per cycle is the duty, cut so the low side keeps its minimum
  task automatic t_pwm;
    int duty [4] = '{20, 3, 0, 8};
    int hi   [4] = '{0, 0, 0, 0};
    int cap;
    cap = 16 - MIN_LOW_CYC;
    wr(ADDR_PERIOD, 32'd15);
    for (int i = 0; i < 4; i++) wr(ADDR_DUTY0 + 8'(4 * i), 32'(duty[i]));
    wr(ADDR_CTRL, ctl(1, 0, 1));
    tick(40);
    for (int c = 0; c < 16; c++) begin
      tick(1);
      for (int i = 0; i < 4; i++) hi[i] += int'(pwm_out[i]);
    end
    for (int i = 0; i < 4; i++) check(32'(hi[i]), 32'(duty[i] < cap ? duty[i] : cap));
    wr(ADDR_CTRL, ctl(0, 0, 1));
    tick(4);
    check({28'h0, pwm_out}, 32'h0);
    wr(ADDR_CTRL, ctl(0, 0, 0));
    $display("t_pwm done");
  endtask

  // ----------
  // Sequence, watchdog and verdict
  // ----------
  task automatic wrap_up;
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    t_reset;
    t_modes;
    t_warn;
    t_uv;
    t_oc(0);
    t_oc(2);
    t_thermal;
    t_cbc;
    t_pwm;
    wrap_up;
  end

  // Whole run needs about 3900 cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    wrap_up;
  end
endmodule // bfpl_host_tb
`default_nettype wire
